// ### rtl/cmt_defs.svh
// Register offsets, field positions, reset values and counts of the compare timer
`ifndef CMT_DEFS_SVH
`define CMT_DEFS_SVH
`define CMT_A_CTRL 5'h00
`define CMT_A_STAT 5'h04
`define CMT_A_CNTH 5'h08
`define CMT_A_CNTL 5'h0c
`define CMT_A_CMPH 5'h10
`define CMT_A_CMPL 5'h14
`define CMT_A_IRQ 5'h18
`define CMT_A_MODE 5'h1c
`define CMT_B_LVLH 7
`define CMT_B_WIDE 6
`define CMT_B_LVLL 3
`define CMT_B_OVERFLOW_FLAG_HIGH 7
`define CMT_B_CMH 6
`define CMT_B_OVERFLOW_FLAG_LOW 3
`define CMT_B_CML 2
`define CMT_B_IRQH 3
`define CMT_B_IRQL 2
`define CMT_RST_CNT 8'h00
`define CMT_RST_CMP 8'hff
`define CMT_RST_REG 8'h00
`define CMT_CM_SUB_CYC 2'h2
`define CMT_IRQ_SUB_CYC 2'h1
`endif

// ### rtl/cmt_pkg.sv
// Types shared by the compare timer modules
package cmt_pkg;
  typedef enum logic [1:0] {
    CS_DIV32 = 2'b00,
    CS_DIV16 = 2'b01,
    CS_DIV4 = 2'b10,
    CS_SUB4 = 2'b11
  } clk_sel_t;
endpackage : cmt_pkg

// ### rtl/half_if.sv
// Signals between the timer top and one 8-bit counter half
`timescale 1ns/1ps
interface half_if;
  logic tick;
  logic mtick;
  logic eq_ext;
  logic count_we;
  logic cmp_we;
  logic clr;
  logic [7:0] wdata;
  logic [7:0] count;
  logic [7:0] cmp;
  logic cm;
  logic ovf;
  modport half (input tick, mtick, eq_ext, count_we, cmp_we, clr, wdata,
                output count, cmp, cm, ovf);
  modport ctrl (output tick, mtick, eq_ext, count_we, cmp_we, clr, wdata,
                input count, cmp, cm, ovf);
endinterface : half_if

// ### rtl/pulse_stretch.sv
// Stretches a one-cycle event to a number of subclock periods
`timescale 1ns/1ps
module pulse_stretch (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic trig_i,
  input wire logic edge_i,
  input wire logic [1:0] len_i,
  output logic valid_o
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;

  // Load on the event, count down on each subclock edge
  assign cnt_d = trig_i ? len_i : ((edge_i && cnt_q != 2'h0) ? cnt_q - 2'h1 : cnt_q);
  assign valid_o = trig_i || (cnt_q != 2'h0);

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i) cnt_q <= 2'h0;
    else cnt_q <= cnt_d;
  end
endmodule : pulse_stretch

// ### rtl/timer_half.sv
// One 8-bit counter half with compare and overflow event logic
`timescale 1ns/1ps
`include "cmt_defs.svh"
module timer_half (
  input wire logic clock_i,
  input wire logic rst_n_i,
  half_if.half hif
);
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [7:0] cmp_q;
  logic at_eq;
  logic wr_eq;

  assign at_eq = (count_q == cmp_q) && hif.eq_ext;
  assign wr_eq = (hif.wdata == count_q) && hif.eq_ext;
  // Match fires as the count leaves the equal value; a compare write overrides it
  assign hif.cm = hif.cmp_we ? wr_eq : (hif.mtick && at_eq); // [RULE_03] [RULE_04] [RULE_22]
  assign hif.ovf = hif.tick && (count_q == 8'hff) && !hif.count_we; // [RULE_07] [RULE_23]
  assign hif.count = count_q;
  assign hif.cmp = cmp_q;

  // Software write beats clear, clear beats increment
  assign count_d = hif.count_we ? hif.wdata : (hif.clr ? 8'h00 :
                   (hif.tick ? count_q + 8'h01 : count_q));

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      count_q <= `CMT_RST_CNT;
      cmp_q <= `CMT_RST_CMP;
    end
    else
    begin
      count_q <= count_d;
      if (hif.cmp_we) cmp_q <= hif.wdata;
    end
  end

  cm_sync_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_05]
    hif.cm && !hif.cmp_we |-> hif.mtick) else $error("match off counting clock");
  clk_stop_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_06]
    !hif.mtick && !hif.cmp_we |-> !hif.cm) else $error("match with clock stopped");
  cmp_wr_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_04]
    hif.cmp_we |-> hif.cm == wr_eq) else $error("compare write match wrong");
  ovf_drop_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_07]
    hif.count_we |-> !hif.ovf) else $error("overflow during counter write");
  wrap_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_23]
    hif.ovf && !hif.clr |=> count_q == 8'h00) else $error("overflow without wrap");
endmodule : timer_half

// ### rtl/compare_timer.sv
// Compare timer top: two 8-bit halves or one 16-bit counter, Avalon-MM registers
//
// What this block does
// [RULE_01] In 8-bit mode each half inverts its toggle pin on its match.
// [RULE_02] A control write coinciding with a match loads the written level.
// [RULE_03] A compare write coinciding with a match cancels that match.
// [RULE_04] But a compare write equal to the count raises a match then.
// [RULE_05] Matches are issued only on the half's own counting tick.
// [RULE_06] With the low half's clock stopped no match is issued; in 8-bit mode the high half still matches on its own clock.
// [RULE_07] A counter write cancels an overflow in the same cycle.
// [RULE_08] With subclock/4, interrupt source lasts 1 and events 2 subclock periods.
// [RULE_09] In active mode a request flag cleared while its source is valid resets.
// [RULE_10] In active mode overflow and match flags cannot clear while valid.
// [RULE_11] Software waits one subclock, ST and two clocks before clearing.
// [RULE_12] Software reads status before writing zero to a flag.
// [RULE_13] Handler masks, later clears flags, then unmasks.
// [RULE_14] Or handler lasts the validity time, then clears flags.
// [RULE_15] In subactive mode all flags clear at any time.
// [RULE_16] In active mode with subclock/4 counter writes are ignored.
// [RULE_17] In active mode with subclock/4 counter reads go through a resync.
// [RULE_18] Software should leave subclock/4 before counter access in active mode.
// [RULE_19] In subactive mode counter access is exact.
// [RULE_20] Width select set splits the counter into two halves with own clocks.
// [RULE_21] Each pin shows its level bit until a match inverts it.
// [RULE_22] A match fires when the count moves on from the equal value.
// [RULE_23] Each half sets its overflow flag on wrap from ff to 00.
// [RULE_24] The subclock passes a two-flop synchroniser before any logic.
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "cmt_defs.svh"
module compare_timer (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic subclk_i,
  input wire logic [4:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  output logic toggle_out_high_o,
  output logic toggle_out_low_o
);
  logic sub_s1_q;
  logic sub_s2_q;
  logic sub_s3_q;
  logic [1:0] sdiv_q;
  logic [4:0] pre_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [7:0] ctrl_q;
  logic [1:0] ovie_q;
  logic [1:0] cclr_q;
  logic [1:0] ovf_q;
  logic [1:0] cmf_q;
  logic [1:0] irqf_q;
  logic [1:0] ien_q;
  logic mode_q;
  logic pin_h_q;
  logic pin_l_q;
  logic [7:0] shadow_h_q;
  logic [7:0] shadow_l_q;
  logic [7:0] wd;
  logic [7:0] rd_mux;

  half_if hi_if ();
  half_if lo_if ();

  // Subclock crossing; the edge detector reads only the second and third flops
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sub_s1_q <= 1'b0;
      sub_s2_q <= 1'b0;
      sub_s3_q <= 1'b0;
    end
    else
    begin
      sub_s1_q <= subclk_i; // [RULE_24]
      sub_s2_q <= sub_s1_q;
      sub_s3_q <= sub_s2_q;
    end
  end

  logic sub_edge;
  assign sub_edge = sub_s2_q && !sub_s3_q;

  // Prescalers: free-running system divider and subclock divide-by-four
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pre_q <= 5'h00;
      sdiv_q <= 2'h0;
    end
    else
    begin
      pre_q <= pre_q + 5'h01;
      if (sub_edge) sdiv_q <= sdiv_q + 2'h1;
    end
  end

  logic t32;
  logic t16;
  logic t4;
  logic tsub;
  assign t32 = (pre_q == 5'h1f);
  assign t16 = (pre_q[3:0] == 4'hf);
  assign t4 = (pre_q[1:0] == 2'h3);
  assign tsub = sub_edge && (sdiv_q == 2'h3);

  // Clock selection per half
  cmt_pkg::clk_sel_t sel_h;
  cmt_pkg::clk_sel_t sel_l;
  logic wide;
  logic active;
  logic tick_h;
  logic tick_l;
  logic sub_h;
  logic sub_l;
  assign sel_h = cmt_pkg::clk_sel_t'(ctrl_q[5:4]);
  assign sel_l = cmt_pkg::clk_sel_t'(ctrl_q[1:0]);
  assign wide = ctrl_q[`CMT_B_WIDE];
  assign active = !mode_q;
  assign tick_l = (sel_l == cmt_pkg::CS_DIV32) ? t32 :
                  (sel_l == cmt_pkg::CS_DIV16) ? t16 :
                  (sel_l == cmt_pkg::CS_DIV4) ? t4 : tsub;
  assign tick_h = (sel_h == cmt_pkg::CS_DIV32) ? t32 :
                  (sel_h == cmt_pkg::CS_DIV16) ? t16 :
                  (sel_h == cmt_pkg::CS_DIV4) ? t4 : tsub;
  assign sub_l = (sel_l == cmt_pkg::CS_SUB4);
  // In 16-bit mode the high half follows the low half's clock
  assign sub_h = !wide ? sub_l : (sel_h == cmt_pkg::CS_SUB4);

  // Avalon slave: one wait state, data registered on the first cycle
  logic req;
  logic wr_fire;
  logic rd_take;
  assign req = read_i || write_i;
  assign waitrequest_o = req && !ack_q;
  assign rd_take = read_i && !ack_q;
  assign wr_fire = write_i && ack_q && byteenable_i[0];
  assign wd = writedata_i[7:0];
  assign readdata_o = rdata_q;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i) ack_q <= 1'b0;
    else ack_q <= req && !ack_q;
  end

  // Write strobes per register
  logic we_ctrl;
  logic we_stat;
  logic we_cnth;
  logic we_cntl;
  logic we_cmph;
  logic we_cmpl;
  logic we_irq;
  logic we_mode;
  assign we_ctrl = wr_fire && (address_i == `CMT_A_CTRL);
  assign we_stat = wr_fire && (address_i == `CMT_A_STAT);
  assign we_cnth = wr_fire && (address_i == `CMT_A_CNTH);
  assign we_cntl = wr_fire && (address_i == `CMT_A_CNTL);
  assign we_cmph = wr_fire && (address_i == `CMT_A_CMPH);
  assign we_cmpl = wr_fire && (address_i == `CMT_A_CMPL);
  assign we_irq = wr_fire && (address_i == `CMT_A_IRQ);
  assign we_mode = wr_fire && (address_i == `CMT_A_MODE);

  // Counter writes are refused while the subclock/4 count is asynchronous
  logic lock_h;
  logic lock_l;
  assign lock_h = active && sub_h; // [RULE_16] [RULE_19]
  assign lock_l = active && sub_l; // [RULE_16] [RULE_19]

  // Half wiring; wide mode splits the halves, with wide clear the halves chain into one 16-bit counter
  assign lo_if.tick = tick_l;
  assign lo_if.mtick = tick_l; // [RULE_05] [RULE_06]
  assign lo_if.eq_ext = 1'b1;
  assign lo_if.count_we = we_cntl && !lock_l; // [RULE_16]
  assign lo_if.cmp_we = we_cmpl;
  assign lo_if.wdata = wd;
  // Split halves clear on their own match; 16-bit mode clears the low byte on the full match
  assign lo_if.clr = wide ? (lo_if.cm && cclr_q[0]) : (hi_if.cm && cclr_q[1]); // [RULE_20]
  assign hi_if.tick = wide ? tick_h : (tick_l && lo_if.count == 8'hff); // [RULE_20]
  assign hi_if.mtick = wide ? tick_h : tick_l;
  assign hi_if.eq_ext = wide || (lo_if.count == lo_if.cmp);
  assign hi_if.count_we = we_cnth && !lock_h; // [RULE_16]
  assign hi_if.cmp_we = we_cmph;
  assign hi_if.wdata = wd;
  assign hi_if.clr = hi_if.cm && cclr_q[1];

  timer_half u_half_h (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .hif(hi_if.half)
  );

  timer_half u_half_l (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .hif(lo_if.half)
  );

  // Event validity windows, stretched in subclock periods under subclock/4
  logic [1:0] len_ev_h;
  logic [1:0] len_ev_l;
  logic [1:0] len_irq_h;
  logic [1:0] len_irq_l;
  logic src_h;
  logic src_l;
  logic v_cm_h;
  logic v_cm_l;
  logic v_ov_h;
  logic v_ov_l;
  logic v_irq_h;
  logic v_irq_l;
  assign len_ev_h = sub_h ? `CMT_CM_SUB_CYC : 2'h0; // [RULE_08]
  assign len_ev_l = sub_l ? `CMT_CM_SUB_CYC : 2'h0; // [RULE_08]
  assign len_irq_h = sub_h ? `CMT_IRQ_SUB_CYC : 2'h0; // [RULE_08]
  assign len_irq_l = sub_l ? `CMT_IRQ_SUB_CYC : 2'h0; // [RULE_08]
  assign src_h = hi_if.cm || (hi_if.ovf && ovie_q[1]);
  assign src_l = lo_if.cm || (lo_if.ovf && ovie_q[0]);

  pulse_stretch u_cm_h (.clock_i(clock_i), .rst_n_i(rst_n_i), .trig_i(hi_if.cm),
    .edge_i(sub_edge), .len_i(len_ev_h), .valid_o(v_cm_h));
  pulse_stretch u_cm_l (.clock_i(clock_i), .rst_n_i(rst_n_i), .trig_i(lo_if.cm),
    .edge_i(sub_edge), .len_i(len_ev_l), .valid_o(v_cm_l));
  pulse_stretch u_ov_h (.clock_i(clock_i), .rst_n_i(rst_n_i), .trig_i(hi_if.ovf),
    .edge_i(sub_edge), .len_i(len_ev_h), .valid_o(v_ov_h));
  pulse_stretch u_ov_l (.clock_i(clock_i), .rst_n_i(rst_n_i), .trig_i(lo_if.ovf),
    .edge_i(sub_edge), .len_i(len_ev_l), .valid_o(v_ov_l));
  pulse_stretch u_irq_h (.clock_i(clock_i), .rst_n_i(rst_n_i), .trig_i(src_h),
    .edge_i(sub_edge), .len_i(len_irq_h), .valid_o(v_irq_h));
  pulse_stretch u_irq_l (.clock_i(clock_i), .rst_n_i(rst_n_i), .trig_i(src_l),
    .edge_i(sub_edge), .len_i(len_irq_l), .valid_o(v_irq_l));

  // Flag updates: set always wins; active mode blocks clears inside the window
  logic [1:0] ovf_set;
  logic [1:0] cmf_set;
  logic [1:0] irq_set;
  logic [1:0] ovf_clr;
  logic [1:0] cmf_clr;
  logic [1:0] irq_clr;
  logic [1:0] ovf_d;
  logic [1:0] cmf_d;
  logic [1:0] irqf_d;
  assign ovf_set = {hi_if.ovf, lo_if.ovf}; // [RULE_23]
  assign cmf_set = {hi_if.cm, lo_if.cm};
  // Active mode re-sets a request flag for as long as its source is valid
  assign irq_set = active ? {v_irq_h, v_irq_l} : {src_h, src_l}; // [RULE_09] [RULE_15]
  assign ovf_clr[1] = we_stat && !wd[`CMT_B_OVERFLOW_FLAG_HIGH] && !(active && v_ov_h); // [RULE_10]
  assign ovf_clr[0] = we_stat && !wd[`CMT_B_OVERFLOW_FLAG_LOW] && !(active && v_ov_l); // [RULE_10]
  assign cmf_clr[1] = we_stat && !wd[`CMT_B_CMH] && !(active && v_cm_h); // [RULE_10]
  assign cmf_clr[0] = we_stat && !wd[`CMT_B_CML] && !(active && v_cm_l); // [RULE_10]
  assign irq_clr[1] = we_irq && !wd[`CMT_B_IRQH]; // [RULE_15]
  assign irq_clr[0] = we_irq && !wd[`CMT_B_IRQL];
  assign ovf_d = ovf_set | (ovf_q & ~ovf_clr);
  assign cmf_d = cmf_set | (cmf_q & ~cmf_clr);
  assign irqf_d = irq_set | (irqf_q & ~irq_clr);

  // Toggle pins: a control write loads the level even against a match
  logic pin_h_d;
  logic pin_l_d;
  assign pin_h_d = we_ctrl ? wd[`CMT_B_LVLH] : (hi_if.cm ? !pin_h_q : pin_h_q); // [RULE_02]
  assign pin_l_d = we_ctrl ? wd[`CMT_B_LVLL] : (lo_if.cm ? !pin_l_q : pin_l_q); // [RULE_01]
  assign toggle_out_high_o = pin_h_q; // [RULE_21]
  assign toggle_out_low_o = pin_l_q; // [RULE_21]

  // Register state
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_q <= `CMT_RST_REG;
      ovie_q <= 2'h0;
      cclr_q <= 2'h0;
      ovf_q <= 2'h0;
      cmf_q <= 2'h0;
      irqf_q <= 2'h0;
      ien_q <= 2'h0;
      mode_q <= 1'b0;
      pin_h_q <= 1'b0;
      pin_l_q <= 1'b0;
    end
    else
    begin
      if (we_ctrl) ctrl_q <= {wd[7:3], 1'b0, wd[1:0]};
      if (we_stat) ovie_q <= {wd[4], wd[0]};
      if (we_stat) cclr_q <= {wd[5], wd[1]};
      if (we_irq) ien_q <= wd[1:0];
      if (we_mode) mode_q <= wd[0];
      ovf_q <= ovf_d;
      cmf_q <= cmf_d;
      irqf_q <= irqf_d;
      pin_h_q <= pin_h_d;
      pin_l_q <= pin_l_d;
    end
  end

  // Resampled counter copies; may trail the live count by one
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      shadow_h_q <= `CMT_RST_CNT;
      shadow_l_q <= `CMT_RST_CNT;
    end
    else
    begin
      shadow_h_q <= hi_if.count; // [RULE_17]
      shadow_l_q <= lo_if.count; // [RULE_17]
    end
  end

  // Read selection; unmapped offsets read zero
  assign rd_mux = (address_i == `CMT_A_CTRL) ? ctrl_q :
    (address_i == `CMT_A_STAT) ? {ovf_q[1], cmf_q[1], cclr_q[1], ovie_q[1],
                                  ovf_q[0], cmf_q[0], cclr_q[0], ovie_q[0]} :
    (address_i == `CMT_A_CNTH) ? (lock_h ? shadow_h_q : hi_if.count) : // [RULE_17] [RULE_19]
    (address_i == `CMT_A_CNTL) ? (lock_l ? shadow_l_q : lo_if.count) : // [RULE_17] [RULE_19]
    (address_i == `CMT_A_CMPH) ? hi_if.cmp :
    (address_i == `CMT_A_CMPL) ? lo_if.cmp :
    (address_i == `CMT_A_IRQ) ? {4'h0, irqf_q, ien_q} :
    (address_i == `CMT_A_MODE) ? {7'h00, mode_q} : 8'h00;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i) rdata_q <= 32'h0000_0000;
    else if (rd_take) rdata_q <= {24'h000000, rd_mux};
  end

  toggle_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_01]
    lo_if.cm && !we_ctrl |=> pin_l_q != $past(pin_l_q)) else $error("low pin not toggled");
  ctrl_wr_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_02]
    we_ctrl |=> pin_h_q == $past(wd[7]) && pin_l_q == $past(wd[3]))
    else $error("pin level not loaded");
  flag_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_10]
    active && v_ov_l && ovf_q[0] |=> ovf_q[0]) else $error("overflow flag cleared");
  irq_reset_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_09]
    active && v_irq_h |=> irqf_q[1]) else $error("request flag lost");
  // Under subclock/4 a match loads two subclock periods of validity
  cm_width_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_08]
    lo_if.cm && sub_l |=> u_cm_l.cnt_q == `CMT_CM_SUB_CYC)
    else $error("match window too short");
  // The window may only close on a subclock edge
  cm_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_08]
    v_cm_l && !lo_if.cm && !sub_edge |=> v_cm_l) else $error("match window cut short");
  irq_width_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_08]
    src_l && sub_l |=> u_irq_l.cnt_q == `CMT_IRQ_SUB_CYC)
    else $error("request window wrong");
  split_clr_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_20]
    wide && lo_if.cm && cclr_q[0] && !lo_if.count_we |=> lo_if.count == 8'h00)
    else $error("low half not cleared on match");
  cnt_lock_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_16]
    we_cntl && lock_l |-> !lo_if.count_we) else $error("locked counter written");
endmodule : compare_timer

// ### dv/subclk_source.sv
// Subclock source standing in for the slow oscillator beside the timer
`timescale 1ns/1ps
module subclk_source #(
  parameter realtime HALF_NS = 257.0
) (
  input wire logic run_i,
  output logic subclk_o
);
  // Runs only while enabled and rests low; phase is unrelated to the system clock
  initial subclk_o = 1'b0;
  always
  begin
    wait (run_i === 1'b1);
    #(HALF_NS) subclk_o = 1'b1;
    #(HALF_NS) subclk_o = 1'b0;
  end
endmodule : subclk_source

// ### dv/testbench.sv
// Self-checking bench for the compare timer through its Avalon-MM register port
`timescale 1ns/1ps
`include "cmt_defs.svh"
module testbench;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sub_run = 1'b0;
  logic subclk;
  logic [4:0] address_i = 5'h00;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [31:0] writedata_i = 32'h00000000;
  logic [3:0] byteenable_i = 4'h0;
  logic [31:0] readdata_o;
  logic waitrequest_o;
  logic toggle_out_high_o;
  logic toggle_out_low_o;
  int mismatches = 0;
  int checked = 0;
  int n;
  logic [7:0] rd;
  logic [7:0] v0;
  logic [7:0] v1;
  logic [4:0] rst_addr [9] = '{`CMT_A_CTRL, `CMT_A_STAT, `CMT_A_CNTH, `CMT_A_CNTL,
    `CMT_A_CMPH, `CMT_A_CMPL, `CMT_A_IRQ, `CMT_A_MODE, 5'h02};
  logic [7:0] rst_val [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};

  // 125 MHz system clock
  always #4 clock_i = ~clock_i;

  compare_timer dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .subclk_i(subclk), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .toggle_out_high_o(toggle_out_high_o), .toggle_out_low_o(toggle_out_low_o)
  );

  subclk_source src (.run_i(sub_run), .subclk_o(subclk));

  // Verdict, reached from the main sequence and from any timeout
  task final_report;
    $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  task check(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task timeout(input string name);
    mismatches++;
    $display("ERROR %s expected done seen stuck", name);
    final_report();
  endtask : timeout

  // Waitrequest is sampled at the edge itself, before that edge's updates land
  task wait_ack;
    int k;
    k = 0;
    do
    begin
      @(posedge clock_i);
      k++;
    end while (waitrequest_o !== 1'b0 && k < 50);
    if (waitrequest_o !== 1'b0) timeout("waitrequest");
  endtask : wait_ack

  // An idle edge after release keeps two requests from touching in one time step
  task bus_write(input logic [4:0] a, input logic [7:0] d, input logic [3:0] be = 4'hf);
    address_i <= a;
    writedata_i <= {24'h000000, d};
    byteenable_i <= be;
    write_i <= 1'b1;
    wait_ack();
    write_i <= 1'b0;
    @(posedge clock_i);
  endtask : bus_write

  task bus_read(input logic [4:0] a, output logic [7:0] d);
    address_i <= a;
    read_i <= 1'b1;
    wait_ack();
    d = readdata_o[7:0];
    read_i <= 1'b0;
    @(posedge clock_i);
  endtask : bus_read

  task expect_reg(input string name, input logic [4:0] a, input logic [7:0] exp);
    bus_read(a, rd);
    check(name, exp, rd);
  endtask : expect_reg

  // Polls one register bit under a bounded count of reads
  task poll(input logic [4:0] a, input int b, input logic val, input int lim);
    int k;
    k = 0;
    do
    begin
      bus_read(a, rd);
      k++;
    end while (rd[b] !== val && k < lim);
    if (rd[b] !== val) timeout("poll");
  endtask : poll

  // Watchdog against a hang anywhere in the sequence
  initial
  begin
    repeat (100000) @(posedge clock_i);
    timeout("watchdog");
  end

  initial
  begin
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    for (int i = 0; i < 9; i++) expect_reg("reset value", rst_addr[i], rst_val[i]);
    bus_write(`CMT_A_CMPL, 8'h10, 4'he);
    expect_reg("byteenable", `CMT_A_CMPL, 8'hff);
    bus_write(5'h02, 8'h5a);
    expect_reg("unmapped", 5'h02, 8'h00);
    $display("test registers done");
    // Compares are set before the counters restart so neither half passes them early
    bus_write(`CMT_A_CMPL, 8'h40);
    bus_write(`CMT_A_CMPH, 8'h04);
    // High half on sys/4, low on sys/32 so the equal count stands long enough to be read
    bus_write(`CMT_A_CTRL, 8'h68);
    check("low pin level", 8'h01, {7'h00, toggle_out_low_o});
    bus_write(`CMT_A_CNTH, 8'h00);
    bus_write(`CMT_A_CNTL, 8'h3c);
    n = 0;
    do
    begin
      bus_read(`CMT_A_CNTL, rd);
      n++;
    end while (rd !== 8'h40 && n < 200);
    check("count reaches compare", 8'h40, rd);
    check("pin held at equality", 8'h01, {7'h00, toggle_out_low_o});
    n = 0;
    while (toggle_out_low_o !== 1'b0 && n < 100)
    begin
      @(posedge clock_i);
      n++;
    end
    check("low pin toggled", 8'h00, {7'h00, toggle_out_low_o});
    check("high pin toggled", 8'h01, {7'h00, toggle_out_high_o});
    bus_read(`CMT_A_STAT, rd);
    check("low match flag", 8'h01, {7'h00, rd[`CMT_B_CML]});
    $display("test toggle done");
    bus_write(`CMT_A_CNTL, 8'hfc);
    poll(`CMT_A_STAT, `CMT_B_OVERFLOW_FLAG_LOW, 1'b1, 80);
    bus_write(`CMT_A_STAT, 8'h00);
    bus_read(`CMT_A_STAT, rd);
    check("overflow cleared", 8'h00, {7'h00, rd[`CMT_B_OVERFLOW_FLAG_LOW]});
    $display("test overflow done");
    // Subclock stopped: the low half is frozen while the high half keeps its own clock
    bus_write(`CMT_A_CTRL, 8'h5b);
    bus_read(`CMT_A_CNTL, v0);
    bus_write(`CMT_A_CNTL, 8'h55);
    expect_reg("locked count", `CMT_A_CNTL, v0);
    bus_write(`CMT_A_CMPL, 8'h20);
    bus_write(`CMT_A_MODE, 8'h01);
    bus_write(`CMT_A_CNTL, 8'h20);
    expect_reg("exact count", `CMT_A_CNTL, 8'h20);
    bus_write(`CMT_A_STAT, 8'h00);
    bus_read(`CMT_A_CNTH, v1);
    v0 = {7'h00, toggle_out_low_o};
    repeat (100) @(posedge clock_i);
    bus_read(`CMT_A_STAT, rd);
    check("no match when stopped", 8'h00, {7'h00, rd[`CMT_B_CML]});
    check("pin still when stopped", v0, {7'h00, toggle_out_low_o});
    bus_read(`CMT_A_CNTH, rd);
    check("high half advances", 8'h01, {7'h00, rd !== v1});
    $display("test stopped clock done");
    // Active mode on subclock/4: clears inside the validity window must not stick
    bus_write(`CMT_A_MODE, 8'h00);
    sub_run <= 1'b1;
    poll(`CMT_A_STAT, `CMT_B_CML, 1'b1, 300);
    bus_write(`CMT_A_IRQ, 8'h00);
    bus_read(`CMT_A_IRQ, rd);
    check("request flag re-set", 8'h01, {7'h00, rd[`CMT_B_IRQL]});
    bus_write(`CMT_A_STAT, 8'h00);
    bus_read(`CMT_A_STAT, rd);
    check("match flag held", 8'h01, {7'h00, rd[`CMT_B_CML]});
    repeat (200) @(posedge clock_i);
    bus_write(`CMT_A_IRQ, 8'h00);
    bus_read(`CMT_A_STAT, rd);
    bus_write(`CMT_A_STAT, 8'h00);
    bus_read(`CMT_A_STAT, rd);
    check("match flag cleared", 8'h00, {7'h00, rd[`CMT_B_CML]});
    bus_read(`CMT_A_IRQ, rd);
    check("request flag cleared", 8'h00, {7'h00, rd[`CMT_B_IRQL]});
    sub_run <= 1'b0;
    $display("test validity window done");
    final_report();
  end
endmodule : testbench
